/* core/bms_boot_select.sv */
`timescale 1ns/10ps

// Behaviour
// - EPROM high, link low: boot memory select drives EPROM chip select.
// - Both low, pin high: host boot; EPROM low, link high, pin high: link boot.
// - Both low, pin low: no boot, execute from external memory.
// - Fetch indicator low during external fetch while no host owns the bus, high otherwise.
// - Fetch indicator released while a host owns the bus.
// - Boot memory select direction follows the two boot select inputs.
module bmf_boot_select
  import bmf_pkg::*;
(
  // Clock and reset
  input  wire logic      i_clock,
  input  wire logic      i_rst,
  // Hardwired configuration straps
  input  wire logic      i_eprom_boot_select,
  input  wire logic      i_link_boot_select,
  // Boot memory select pin
  input  wire logic      i_boot_memory_select_n,
  output logic           o_boot_memory_select_n,
  output logic           o_boot_memory_select_oe_n,
  // EPROM chip select request from boot loader
  input  wire logic      i_eprom_select,
  // Fetch indicator
  input  wire logic      i_ext_fetch,
  input  wire logic      i_host_owns_bus,
  output logic           o_core_fetch_indicator_n,
  output logic           o_core_fetch_indicator_oe_n,
  // Decoded boot mode
  output bmf_mode_t      o_boot_mode,
  output logic           o_mode_reserved
);

  bmf_strap_t strap_reg;
  bmf_mode_t  mode_next;
  logic       captured_reg;

  // Straps follow the pins while in reset and at the first edge after release, then frozen
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      captured_reg <= RST_CAPTURED;
    end else begin
      captured_reg <= 1'h1;
    end
  end

  // Strap sampling continues until the first edge after release
  always_ff @(posedge i_clock) begin
    if (!captured_reg) begin
      strap_reg.eprom_boot_select <= i_eprom_boot_select;
      strap_reg.link_boot_select  <= i_link_boot_select;
      strap_reg.pin_low           <= ~i_boot_memory_select_n;
    end
  end

  // Mode decode from the straps
  always_comb begin
    mode_next = BMF_MODE_RSVD;
    if (strap_reg.eprom_boot_select && !strap_reg.link_boot_select) begin
      mode_next = BMF_MODE_EPROM;
    end else if (!strap_reg.eprom_boot_select && !strap_reg.link_boot_select
                 && !strap_reg.pin_low) begin
      mode_next = BMF_MODE_HOST;
    end else if (!strap_reg.eprom_boot_select && strap_reg.link_boot_select
                 && !strap_reg.pin_low) begin
      mode_next = BMF_MODE_LINK;
    end else if (!strap_reg.eprom_boot_select && !strap_reg.link_boot_select
                 && strap_reg.pin_low) begin
      mode_next = BMF_MODE_NONE;
    end
  end

  // Decoded mode register, loaded at the first edge after reset release, then held
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      o_boot_mode     <= RST_MODE;
      o_mode_reserved <= RST_RESERVED;
    end else if (!captured_reg) begin
      o_boot_mode     <= mode_next;
      o_mode_reserved <= (mode_next == BMF_MODE_RSVD);
    end
  end

  // Boot memory select pin direction and chip select drive
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      o_boot_memory_select_oe_n <= RST_SELECT_OE_N;
      o_boot_memory_select_n    <= RST_SELECT_OUT;
    end else begin
      o_boot_memory_select_oe_n <= ~(i_eprom_boot_select
                                     & ~i_link_boot_select);
      o_boot_memory_select_n    <= ~(captured_reg
                                     && o_boot_mode == BMF_MODE_EPROM
                                     && i_eprom_select);
    end
  end

  // Fetch indicator drive and release
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      o_core_fetch_indicator_n    <= RST_FETCH_OUT;
      o_core_fetch_indicator_oe_n <= RST_FETCH_OE_N;
    end else begin
      o_core_fetch_indicator_n    <= ~(i_ext_fetch
                                       & ~i_host_owns_bus);
      o_core_fetch_indicator_oe_n <= i_host_owns_bus;
    end
  end

  // Checks on the fetch indicator
  property p_fetch_release;
    @(posedge i_clock) disable iff (i_rst)
      i_host_owns_bus |=> o_core_fetch_indicator_oe_n;
  endproperty
  a_fetch_release: assert property (p_fetch_release)
    else $error("fetch indicator driven while host owns bus");

  property p_fetch_low;
    @(posedge i_clock) disable iff (i_rst)
      (i_ext_fetch && !i_host_owns_bus) |=> !o_core_fetch_indicator_n;
  endproperty
  a_fetch_low: assert property (p_fetch_low)
    else $error("fetch indicator not low during fetch");

  property p_fetch_high;
    @(posedge i_clock) disable iff (i_rst)
      !i_ext_fetch |=> o_core_fetch_indicator_n;
  endproperty
  a_fetch_high: assert property (p_fetch_high)
    else $error("fetch indicator low without fetch");

  property p_fetch_host_high;
    @(posedge i_clock) disable iff (i_rst)
      i_host_owns_bus |=> o_core_fetch_indicator_n;
  endproperty
  a_fetch_host_high: assert property (p_fetch_host_high)
    else $error("fetch indicator low while host owns bus");

  // Checks on the boot memory select direction
  property p_select_dir;
    @(posedge i_clock) disable iff (i_rst)
      (i_eprom_boot_select && !i_link_boot_select)
        |=> !o_boot_memory_select_oe_n;
  endproperty
  a_select_dir: assert property (p_select_dir)
    else $error("boot memory select not driven in EPROM mode");

  property p_select_input;
    @(posedge i_clock) disable iff (i_rst)
      !i_eprom_boot_select |=> o_boot_memory_select_oe_n;
  endproperty
  a_select_input: assert property (p_select_input)
    else $error("boot memory select driven in input mode");

  // Checks on the decoded boot mode: decode at the first edge after release, then hold
  property p_mode_hold;
    @(posedge i_clock) disable iff (i_rst)
      ($past(captured_reg) && captured_reg) |-> $stable(o_boot_mode);
  endproperty
  a_mode_hold: assert property (p_mode_hold)
    else $error("boot mode changed outside reset");

  property p_eprom_mode;
    @(posedge i_clock) disable iff (i_rst)
      (!captured_reg && i_eprom_boot_select && !i_link_boot_select)
        |=> o_boot_mode == BMF_MODE_EPROM;
  endproperty
  a_eprom_mode: assert property (p_eprom_mode)
    else $error("EPROM boot not decoded");

  property p_host_mode;
    @(posedge i_clock) disable iff (i_rst)
      (!captured_reg && !i_eprom_boot_select && !i_link_boot_select
       && i_boot_memory_select_n)
        |=> o_boot_mode == BMF_MODE_HOST;
  endproperty
  a_host_mode: assert property (p_host_mode)
    else $error("host boot not decoded");

  property p_link_mode;
    @(posedge i_clock) disable iff (i_rst)
      (!captured_reg && !i_eprom_boot_select && i_link_boot_select
       && i_boot_memory_select_n)
        |=> o_boot_mode == BMF_MODE_LINK;
  endproperty
  a_link_mode: assert property (p_link_mode)
    else $error("link boot not decoded");

  property p_none_mode;
    @(posedge i_clock) disable iff (i_rst)
      (!captured_reg && !i_eprom_boot_select && !i_link_boot_select
       && !i_boot_memory_select_n)
        |=> o_boot_mode == BMF_MODE_NONE;
  endproperty
  a_none_mode: assert property (p_none_mode)
    else $error("no-boot mode not decoded");

  property p_rsvd_decode;
    @(posedge i_clock) disable iff (i_rst)
      (!captured_reg
       && ((i_eprom_boot_select && i_link_boot_select)
           || (!i_eprom_boot_select && i_link_boot_select
               && !i_boot_memory_select_n)))
        |=> o_mode_reserved;
  endproperty
  a_rsvd_decode: assert property (p_rsvd_decode)
    else $error("reserved straps not flagged");

  property p_rsvd_flag;
    @(posedge i_clock) disable iff (i_rst)
      o_mode_reserved |-> o_boot_mode == BMF_MODE_RSVD;
  endproperty
  a_rsvd_flag: assert property (p_rsvd_flag)
    else $error("reserved flag without reserved mode");

  // Check on the EPROM chip select
  property p_eprom_cs;
    @(posedge i_clock) disable iff (i_rst)
      (captured_reg && o_boot_mode == BMF_MODE_EPROM && i_eprom_select)
        |=> !o_boot_memory_select_n;
  endproperty
  a_eprom_cs: assert property (p_eprom_cs)
    else $error("EPROM chip select not asserted");

  // Main scenarios reached
  c_eprom: cover property (@(posedge i_clock) disable iff (i_rst)
    o_boot_mode == BMF_MODE_EPROM && !o_boot_memory_select_n);
  c_link: cover property (@(posedge i_clock) disable iff (i_rst)
    o_boot_mode == BMF_MODE_LINK);
  c_none: cover property (@(posedge i_clock) disable iff (i_rst)
    o_boot_mode == BMF_MODE_NONE);
  c_host_bus: cover property (@(posedge i_clock) disable iff (i_rst)
    i_ext_fetch ##1 i_host_owns_bus);

endmodule

/* core/bms_pkg.sv */
package bmf_pkg;

  // Decoded boot modes
  typedef enum logic [2:0] {
    BMF_MODE_EPROM,
    BMF_MODE_HOST,
    BMF_MODE_LINK,
    BMF_MODE_NONE,
    BMF_MODE_RSVD
  } bmf_mode_t;

  // Hardwired configuration straps
  typedef struct packed {
    logic eprom_boot_select;
    logic link_boot_select;
    logic pin_low;
  } bmf_strap_t;

  // Values after reset
  localparam logic      RST_SELECT_OE_N = 1'h1;
  localparam logic      RST_SELECT_OUT  = 1'h1;
  localparam logic      RST_FETCH_OUT   = 1'h1;
  localparam logic      RST_FETCH_OE_N  = 1'h1;
  localparam logic      RST_CAPTURED    = 1'h0;
  localparam logic      RST_RESERVED    = 1'h0;
  localparam bmf_mode_t RST_MODE        = BMF_MODE_RSVD;

endpackage

/* sim/bms_far_end.sv */
`timescale 1ns/10ps

// Board side of the boot memory select wire
module bmf_far_end (
  // Device pin drive
  input  wire logic i_select_out_n,
  input  wire logic i_select_oe_n,
  // Hardwired board level of the boot memory select strap
  input  wire logic i_strap_level,
  // Resolved wire
  output logic      o_wire
);
  // Board level shows once the device releases the pin
  assign o_wire = i_select_oe_n ? i_strap_level : i_select_out_n;
endmodule

/* sim/tb_top.sv */
`timescale 1ns/10ps

module tb_top;
  import bmf_pkg::*;
  logic      i_clock, i_rst, eb, lb, lvl, sel, fet, host, pin;
  logic      sel_pin_n, sel_oe_n, fetch_n, fetch_oe_n, rsv;
  bmf_mode_t mode;
  int        err_count, samples_checked, cyc;

  // Board wire model
  bmf_far_end far (.i_select_out_n(sel_pin_n), .i_select_oe_n(sel_oe_n),
    .i_strap_level(lvl), .o_wire(pin));

  bmf_boot_select uut (.i_clock(i_clock), .i_rst(i_rst),
    .i_eprom_boot_select(eb), .i_link_boot_select(lb),
    .i_boot_memory_select_n(pin), .o_boot_memory_select_n(sel_pin_n),
    .o_boot_memory_select_oe_n(sel_oe_n), .i_eprom_select(sel),
    .i_ext_fetch(fet), .i_host_owns_bus(host),
    .o_core_fetch_indicator_n(fetch_n),
    .o_core_fetch_indicator_oe_n(fetch_oe_n),
    .o_boot_mode(mode), .o_mode_reserved(rsv));

  // Clock, 25 ns period
  initial begin
    i_clock = 1'h0;
    forever #12.5 i_clock = ~i_clock;
  end

  task automatic chk_bit(input string nm, input logic e, input logic g);
    samples_checked++;
    if (g !== e) begin
      err_count++;
      $display("mismatch %s expected %b seen %b", nm, e, g);
    end
  endtask

  task automatic chk_mode(input bmf_mode_t e, input bmf_mode_t g);
    samples_checked++;
    if (g !== e) begin
      err_count++;
      $display("mismatch mode expected %0d seen %0d", e, g);
    end
  endtask

  // Reset 16 cycles with given straps, then judge decode
  task automatic boot(input logic e, l, p, input bmf_mode_t m);
    i_rst = 1'h1;
    eb = e;
    lb = l;
    lvl = p;
    repeat (16) @(negedge i_clock);
    i_rst = 1'h0;
    repeat (3) @(negedge i_clock);
    chk_mode(m, mode);
    chk_bit("reserved", m == BMF_MODE_RSVD, rsv);
    chk_bit("select_oe_n", !(e && !l), sel_oe_n);
  endtask

  task automatic t_modes;
    boot(1'h1, 1'h0, 1'h1, BMF_MODE_EPROM);
    boot(1'h0, 1'h0, 1'h1, BMF_MODE_HOST);
    boot(1'h0, 1'h1, 1'h1, BMF_MODE_LINK);
    boot(1'h0, 1'h0, 1'h0, BMF_MODE_NONE);
    boot(1'h0, 1'h1, 1'h0, BMF_MODE_RSVD);
    boot(1'h1, 1'h1, 1'h0, BMF_MODE_RSVD);
  endtask

  // Straps move after reset: mode frozen, direction live
  task automatic t_hold;
    boot(1'h0, 1'h0, 1'h1, BMF_MODE_HOST);
    eb = 1'h1;
    lvl = 1'h0;
    sel = 1'h1;
    @(negedge i_clock);
    chk_mode(BMF_MODE_HOST, mode);
    chk_bit("select_oe_n", 1'h0, sel_oe_n);
    chk_bit("select_n", 1'h1, sel_pin_n);
    sel = 1'h0;
  endtask

  // EPROM chip select on the wire
  task automatic t_eprom;
    boot(1'h1, 1'h0, 1'h1, BMF_MODE_EPROM);
    sel = 1'h1;
    @(negedge i_clock);
    chk_bit("pin", 1'h0, pin);
    sel = 1'h0;
    @(negedge i_clock);
    chk_bit("pin", 1'h1, pin);
  endtask

  // Fetch indicator, then host takes and returns the bus
  task automatic t_fetch;
    fet = 1'h1;
    @(negedge i_clock);
    chk_bit("fetch_n", 1'h0, fetch_n);
    chk_bit("fetch_oe_n", 1'h0, fetch_oe_n);
    host = 1'h1;
    @(negedge i_clock);
    chk_bit("fetch_oe_n", 1'h1, fetch_oe_n);
    chk_bit("fetch_n", 1'h1, fetch_n);
    host = 1'h0;
    fet = 1'h0;
    @(negedge i_clock);
    chk_bit("fetch_n", 1'h1, fetch_n);
    chk_bit("fetch_oe_n", 1'h0, fetch_oe_n);
  endtask

  task automatic tally_and_finish;
    $display("errors %0d checks %0d", err_count, samples_checked);
    if (err_count == 0 && samples_checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // Hang guard
  always @(posedge i_clock) begin
    cyc++;
    if (cyc == 2000) begin
      err_count++;
      tally_and_finish();
    end
  end

  // Main sequence, board holds every reset asserted from power-up
  initial begin
    {i_rst, eb, lb, lvl, sel, fet, host} = 7'h40;
    @(negedge i_clock);
    t_modes();
    t_hold();
    t_eprom();
    t_fetch();
    tally_and_finish();
  end
endmodule
